// ==== hdl/watchdog_timer_with_reset.sv ====
`timescale 1ns/1ps
`include "wd_defs.svh"

// ****************************************************************
// Watchdog timer with system reset
// ****************************************************************
module watchdog_timer_with_reset #(
  parameter int STARTUP_CYCLES = `WD_STARTUP_CYC
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire wd_pkg::bus_req_t  bus_req,
  output logic [7:0]             bus_rdata,
  input  wire logic              wd_osc,
  input  wire logic              always_on_fuse,
  input  wire logic              restart_req,
  input  wire logic              irq_vector_ack,
  output logic                   timeout_irq,
  output logic                   sys_reset_pulse,
  output logic                   cpu_hold
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic             osc_s;
  logic             fuse_s;
  logic             osc_d_ff;
  logic [19:0]      cnt_ff;
  logic [3:0]       sel_ff;
  logic             re_ff;
  logic             tie_ff;
  logic             tif_ff;
  logic             reset_flag_ff;
  logic [2:0]       unlock_ff;
  logic             tick;
  logic             re_eff;
  logic             tie_eff;
  logic             window;
  logic             ctrl_wr;
  logic             cause_wr;
  logic             arm;
  logic             prot_wr;
  logic             running;
  logic             expire;
  logic             irq_set;
  logic             wd_rst;
  wd_pkg::wd_mode_t mode;
  logic [7:0]       ctrl_view;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Last counter value before expiry for a select code.
  function automatic logic [19:0] last_count(input logic [3:0] sel);
    logic [31:0] full;
    full = (32'(`WD_BASE_CYCLES) << sel) - 32'd1;
    return full[19:0];
  endfunction : last_count

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // The oscillator and fuse come from outside this clock domain.
  wd_sync2 u_osc_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (wd_osc),
    .q       (osc_s)
  );

  wd_sync2 u_fuse_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .d       (always_on_fuse),
    .q       (fuse_s)
  );

  // ****************************************************************
  // Decode
  // ****************************************************************

  // The reset flag and the fuse force the reset enable; only the fuse masks the interrupt enable.
  assign re_eff   = re_ff | reset_flag_ff | fuse_s;
  assign tie_eff  = tie_ff & ~fuse_s;
  assign mode     = wd_pkg::wd_mode_t'({re_eff, tie_eff});
  assign window   = (unlock_ff != 3'd0);
  assign ctrl_wr  = bus_req.wr & (bus_req.addr == `WD_CTRL_ADDR);
  assign cause_wr = bus_req.wr & (bus_req.addr == `WD_CAUSE_ADDR);
  // Arming needs both the unlock and the reset enable bit written.
  assign arm      = ctrl_wr & bus_req.wdata[`WD_B_UNLOCK] &
                    bus_req.wdata[`WD_B_RE];
  assign prot_wr  = ctrl_wr & window & ~bus_req.wdata[`WD_B_UNLOCK];

  // Expiry is judged on an oscillator edge, never on the fast clock.
  assign tick     = osc_s & ~osc_d_ff;
  assign running  = (mode != wd_pkg::MODE_STOP);
  // Greater-or-equal catches a switch to a shorter time-out.
  assign expire   = tick & running & (cnt_ff >= last_count(sel_ff));

  // Pick the action for this expiry from the active mode.
  always_comb begin
    irq_set = 1'b0;
    wd_rst  = 1'b0;
    unique case (mode)
      wd_pkg::MODE_STOP: begin
        irq_set = 1'b0;
      end
      wd_pkg::MODE_IRQ: begin
        irq_set = expire;
      end
      wd_pkg::MODE_RST: begin
        wd_rst = expire;
      end
      wd_pkg::MODE_IRQ_RST: begin
        irq_set = expire & ~tif_ff;
        wd_rst  = expire & tif_ff;
      end
    endcase
  end

  // ****************************************************************
  // Counter
  // ****************************************************************

  // Delayed oscillator sample for the edge detector.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_d_ff <= 1'b0;
    end else begin
      osc_d_ff <= osc_s;
    end
  end

  // The counter parks at zero while stopped to keep it quiet.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 20'h00000;
    end else if (restart_req | expire | ~running) begin
      cnt_ff <= 20'h00000;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 20'h00001;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************

  // Unlock window: four cycles after the arming write.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unlock_ff <= 3'd0;
    end else if (wd_rst | prot_wr) begin
      unlock_ff <= 3'd0;
    end else if (arm) begin
      unlock_ff <= `WD_UNLOCK_CYCLES;
    end else if (window) begin
      unlock_ff <= unlock_ff - 3'd1;
    end
  end

  // Reset enable can be set any time but cleared only in the window.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      re_ff <= 1'b0;
    end else if (prot_wr) begin
      re_ff <= bus_req.wdata[`WD_B_RE];
    end else if (ctrl_wr & bus_req.wdata[`WD_B_RE]) begin
      re_ff <= 1'b1;
    end
  end

  // Reserved select codes are dropped so the field stays legal.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= 4'h0;
    end else if (wd_rst) begin
      sel_ff <= 4'h0;
    end else if (prot_wr) begin
      if ({bus_req.wdata[`WD_B_SEL3],
           bus_req.wdata[`WD_B_SEL_HI:`WD_B_SEL_LO]} <= `WD_SEL_MAX) begin
        sel_ff <= {bus_req.wdata[`WD_B_SEL3],
                   bus_req.wdata[`WD_B_SEL_HI:`WD_B_SEL_LO]};
      end
    end
  end

  // In combined mode the vector drops back to plain reset mode.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tie_ff <= 1'b0;
    end else if (wd_rst) begin
      tie_ff <= 1'b0;
    end else if (ctrl_wr) begin
      tie_ff <= bus_req.wdata[`WD_B_TIE];
    end else if (irq_vector_ack & re_eff) begin
      tie_ff <= 1'b0;
    end
  end

  // A new time-out beats a clear arriving in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tif_ff <= 1'b0;
    end else if (irq_set) begin
      tif_ff <= 1'b1;
    end else if (wd_rst | irq_vector_ack |
                 (ctrl_wr & bus_req.wdata[`WD_B_TIF])) begin
      tif_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Reset cause flag
  // ****************************************************************

  // Only power-on reset or a written zero clears it, so the
  // watchdog comes back enabled after its own reset.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_flag_ff <= 1'b0;
    end else if (wd_rst) begin
      reset_flag_ff <= 1'b1;
    end else if (cause_wr & ~bus_req.wdata[`WD_B_RST_FLAG]) begin
      reset_flag_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // One clock of reset per expiry in reset mode, or in combined mode with the interrupt flag already set.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset_pulse <= 1'b0;
    end else begin
      sys_reset_pulse <= wd_rst;
    end
  end

  // Level interrupt, also usable as a wake-up request.
  assign timeout_irq = tif_ff & tie_eff;

  assign ctrl_view = {tif_ff, tie_eff, sel_ff[3], window, re_eff,
                      sel_ff[2:0]};

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= `WD_CTRL_RST;
    end else if (bus_req.rd & (bus_req.addr == `WD_CTRL_ADDR)) begin
      bus_rdata <= ctrl_view;
    end else if (bus_req.rd & (bus_req.addr == `WD_CAUSE_ADDR)) begin
      bus_rdata <= {4'h0, reset_flag_ff, 3'b000};
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  wd_startup_delay #(
    .CYCLES (STARTUP_CYCLES)
  ) u_startup (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .rst_pulse (sys_reset_pulse),
    .cpu_hold  (cpu_hold)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_arm_quiet;
    arm ##1 (!bus_req.wr)[*4];
  endsequence

  sequence s_expire_rst;
    expire && (mode == wd_pkg::MODE_RST);
  endsequence

  AST_RST_ONE_CYCLE : assert property ($rose(sys_reset_pulse) |=> !sys_reset_pulse)
    else $error("Watchdog reset pulse longer than one cycle.");

  AST_TICK_ADVANCE : assert property (tick && running && !expire && !restart_req
    |=> cnt_ff == $past(cnt_ff) + 20'h00001)
    else $error("Counter did not advance on oscillator tick.");

  AST_RESET_MODE : assert property (s_expire_rst |=> sys_reset_pulse ##1 reset_flag_ff)
    else $error("Reset mode expiry gave no reset.");

  AST_RESTART : assert property (restart_req |=> cnt_ff == 20'h00000)
    else $error("Restart did not clear the counter.");

  AST_IRQ_MODE : assert property (expire && mode == wd_pkg::MODE_IRQ
    |=> tif_ff && !sys_reset_pulse)
    else $error("Interrupt mode expiry misbehaved.");

  AST_COMBINED : assert property (expire && mode == wd_pkg::MODE_IRQ_RST
    |=> (tif_ff && !sys_reset_pulse) || ($past(tif_ff) && sys_reset_pulse))
    else $error("Combined mode expiry misbehaved.");

  AST_FUSE : assert property (fuse_s && bus_req.rd && bus_req.addr == `WD_CTRL_ADDR
    |=> bus_rdata[`WD_B_RE] && !bus_rdata[`WD_B_TIE])
    else $error("Fuse did not force reset mode.");

  AST_UNLOCK_CLEAR : assert property (s_arm_quiet |=> !window)
    else $error("Change unlock did not clear after four cycles.");

  AST_PROTECTED : assert property (ctrl_wr && !window && re_ff |=> re_ff)
    else $error("Reset enable cleared outside the window.");

  AST_FLAG_FORCE : assert property (reset_flag_ff && bus_req.rd && bus_req.addr == `WD_CTRL_ADDR
    |=> bus_rdata[`WD_B_RE])
    else $error("Reset flag did not force reset enable.");

  AST_STOPPED : assert property (tick && mode == wd_pkg::MODE_STOP
    |=> !sys_reset_pulse && cnt_ff == 20'h00000)
    else $error("Stopped watchdog acted on expiry.");

  AST_VECTOR_CLEAR : assert property (irq_vector_ack && !irq_set |=> !tif_ff)
    else $error("Vector did not clear interrupt flag.");

  AST_STAY_ON : assert property (sys_reset_pulse |-> re_eff ##1 re_eff)
    else $error("Watchdog disabled after its own reset.");

  // A reserved code must leave the stored time-out untouched.
  AST_RESERVED_KEEP : assert property (prot_wr && !wd_rst &&
    ({bus_req.wdata[`WD_B_SEL3], bus_req.wdata[`WD_B_SEL_HI:`WD_B_SEL_LO]} > `WD_SEL_MAX)
    |=> sel_ff == $past(sel_ff))
    else $error("Reserved select code was taken.");

  AST_HOLD_FOLLOWS : assert property (sys_reset_pulse |=> cpu_hold)
    else $error("Core hold did not follow the reset pulse.");

  AST_SET_WINS : assert property (irq_set |=> tif_ff)
    else $error("Interrupt flag not set on expiry.");

endmodule : watchdog_timer_with_reset

// ==== hdl/wd_defs.svh ====
// What this block does
// - Watchdog reset pulse lasts one clock.
// - Pulse falling edge starts start-up delay.
// - Counter advances on separate 128 kHz oscillator.
// - Expiry gives interrupt or reset per mode.
// - Interrupt mode interrupts, never resets, wakes.
// - Reset mode expiry resets the system.
// - Combined mode: interrupt first, then reset.
// - Fuse forces reset enable one, interrupt zero.
// - Protected changes only inside four-cycle window.
// - Time-outs span sixteen milliseconds to eight seconds.
// - Watchdog stays enabled after its own reset.
// - Change-unlock bit self-clears after four cycles.
// - Reset flag forces reset enable to one.
// - Select field: 2048 cycles doubling, codes reserved.
// - Interrupt flag set, cleared by vector/write.
`ifndef WD_DEFS_SVH
`define WD_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WD_CTRL_ADDR    8'h60
`define WD_CAUSE_ADDR   8'h54
`define WD_CTRL_RST     8'h00

// Control register field positions.
`define WD_B_TIF        7
`define WD_B_TIE        6
`define WD_B_SEL3       5
`define WD_B_UNLOCK     4
`define WD_B_RE         3
`define WD_B_SEL_HI     2
`define WD_B_SEL_LO     0
// Reset cause register field position.
`define WD_B_RST_FLAG   3

// ****************************************************************
// Timing
// ****************************************************************
`define WD_UNLOCK_CYCLES 3'd4
`define WD_BASE_CYCLES   2048
`define WD_SEL_MAX       4'h9
`define WD_OSC_KHZ       128
`define WD_TIMEOUT_MIN_MS 16
`define WD_TIMEOUT_MAX_MS 8000
`define WD_CLK_MHZ       20
`define WD_STARTUP_US    4100
`define WD_STARTUP_CYC   (`WD_STARTUP_US * `WD_CLK_MHZ)

`endif

// ==== hdl/wd_pkg.sv ====
package wd_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************

  // Action taken when the counter expires.
  typedef enum logic [1:0] {
    MODE_STOP    = 2'b00,
    MODE_IRQ     = 2'b01,
    MODE_RST     = 2'b10,
    MODE_IRQ_RST = 2'b11
  } wd_mode_t;

  // One register bus request, valid for one cycle.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

endpackage : wd_pkg

// ==== hdl/wd_sync2.sv ====
`timescale 1ns/1ps

// ****************************************************************
// Two-stage synchroniser
// ****************************************************************
module wd_sync2 (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);

  logic meta_ff;

  // The first stage feeds only the second; nothing else reads it.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 1'b0;
      q       <= 1'b0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule : wd_sync2

// ==== hdl/wd_startup_delay.sv ====
`timescale 1ns/1ps
`include "wd_defs.svh"

// ****************************************************************
// Start-up delay counter
// ****************************************************************
module wd_startup_delay #(
  parameter int CYCLES = `WD_STARTUP_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic rst_pulse,
  output logic      cpu_hold
);

  logic        pulse_d_ff;
  logic [23:0] left_ff;
  logic        fall;

  assign fall = pulse_d_ff & ~rst_pulse;

  // Remember the pulse to find its falling edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_d_ff <= 1'b0;
    end else begin
      pulse_d_ff <= rst_pulse;
    end
  end

  // The delay is counted from the falling edge, not the rising one.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      left_ff <= 24'h000000;
    end else if (fall) begin
      left_ff <= 24'(CYCLES);
    end else if (left_ff != 24'h000000) begin
      left_ff <= left_ff - 24'h000001;
    end
  end

  // Hold the core from the pulse until the delay has run out.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_hold <= 1'b0;
    end else begin
      cpu_hold <= rst_pulse | fall | (left_ff > 24'h000001);
    end
  end

  AST_DELAY_START : assert property (@(posedge ref_clk) disable iff (!rst_n)
    $fell(rst_pulse) |=> cpu_hold ##1 (left_ff == 24'(CYCLES - 1)))
    else $error("Start-up delay did not start on pulse fall.");

endmodule : wd_startup_delay

// ==== bench/test_watchdog_timer_with_reset.sv ====
`timescale 1ns/1ps
`include "wd_defs.svh"

module test_watchdog_timer_with_reset;
  // ****************************************************************
  // Bench signals and the device under test
  // ****************************************************************
  localparam int HOLD = 8;
  localparam int LIMIT_NS = 5000000;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  wd_pkg::bus_req_t  bus_req = '0;
  logic [7:0]        bus_rdata;
  logic              wd_osc = 1'b0;
  logic              always_on_fuse = 1'b0;
  logic              restart_req = 1'b0;
  logic              irq_vector_ack = 1'b0;
  logic              timeout_irq;
  logic              sys_reset_pulse;
  logic              cpu_hold;
  logic [1:0]        osc_div = 2'd0;
  int                failures = 0;
  int                total_checks = 0;

  watchdog_timer_with_reset #(.STARTUP_CYCLES(HOLD)) DUT (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .bus_req         (bus_req),
    .bus_rdata       (bus_rdata),
    .wd_osc          (wd_osc),
    .always_on_fuse  (always_on_fuse),
    .restart_req     (restart_req),
    .irq_vector_ack  (irq_vector_ack),
    .timeout_irq     (timeout_irq),
    .sys_reset_pulse (sys_reset_pulse),
    .cpu_hold        (cpu_hold)
  );

  // The clock toggles every 25 ns, half of its 50 ns period.
  always #25 ref_clk = ~ref_clk;

  // The oscillator runs far above its real rate so that a full time-out fits the run; a tick is four clocks.
  always @(posedge ref_clk) begin
    osc_div <= osc_div + 2'd1;
    wd_osc  <= osc_div[1];
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      failures++;
    end
  endtask : check

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask : wr8

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      bus_req <= '0;
    end
  endtask : idle

  // Read data are taken in the middle of the single cycle in which they stand.
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    @(negedge ref_clk);
    d = bus_rdata;
  endtask : rd8

  task automatic expect_reg(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd8(a, d);
    check(name, exp, d);
  endtask : expect_reg

  // Arming write, then a gap of idle cycles, then the protected write.
  task automatic unlock(input int gap, input logic [7:0] d);
    wr8(`WD_CTRL_ADDR, 8'h18);
    idle(gap);
    wr8(`WD_CTRL_ADDR, d);
    idle(1);
  endtask : unlock

  task automatic pulse_restart();
    @(posedge ref_clk);
    restart_req <= 1'b1;
    @(posedge ref_clk);
    restart_req <= 1'b0;
  endtask : pulse_restart

  // Waits until either output rises, giving up after hi cycles.
  task automatic wait_evt(input int hi, output int n);
    n = 0;
    while (n < hi && sys_reset_pulse !== 1'b1 && timeout_irq !== 1'b1) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_evt

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    expect_reg("ctrl reset", `WD_CTRL_ADDR, `WD_CTRL_RST);
    expect_reg("cause reset", `WD_CAUSE_ADDR, 8'h00);
    wr8(8'h61, 8'hff);
    idle(1);
    expect_reg("unmapped read", 8'h61, 8'h00);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_unlock();
    logic [7:0] d;
    wr8(`WD_CTRL_ADDR, 8'h18);
    rd8(`WD_CTRL_ADDR, d);
    check("window open c1", 1'b1, d[4]);
    rd8(`WD_CTRL_ADDR, d);
    check("window open c3", 1'b1, d[4]);
    rd8(`WD_CTRL_ADDR, d);
    check("window shut c5", 8'h08, d);
    unlock(4, 8'h01);
    expect_reg("late write refused", `WD_CTRL_ADDR, 8'h08);
    unlock(3, 8'h01);
    expect_reg("last window cycle", `WD_CTRL_ADDR, 8'h01);
    wr8(`WD_CTRL_ADDR, 8'h10);
    wr8(`WD_CTRL_ADDR, 8'h02);
    idle(1);
    expect_reg("arm without re", `WD_CTRL_ADDR, 8'h01);
    unlock(0, 8'h00);
    expect_reg("back to back", `WD_CTRL_ADDR, 8'h00);
    $display("test unlock done");
  endtask : t_unlock

  task automatic t_reset_mode();
    int n;
    int h;
    wr8(`WD_CTRL_ADDR, 8'h08);
    idle(1);
    pulse_restart();
    wait_evt(6000, n);
    check("no early expiry", 6000, n);
    pulse_restart();
    wait_evt(8200, n);
    check("reset pulse", 1'b1, sys_reset_pulse);
    check("reset timing", 1'b1, n >= 8188 && n <= 8200);
    @(negedge ref_clk);
    check("pulse one cycle", 1'b0, sys_reset_pulse);
    check("hold starts", 1'b1, cpu_hold);
    h = 0;
    while (cpu_hold === 1'b1 && h < 40) begin
      @(negedge ref_clk);
      h++;
    end
    check("hold length", 1'b1, h >= HOLD && h <= HOLD + 2);
    expect_reg("reset flag", `WD_CAUSE_ADDR, 8'h08);
    unlock(0, 8'h00);
    expect_reg("enable stuck", `WD_CTRL_ADDR, 8'h08);
    wr8(`WD_CAUSE_ADDR, 8'h00);
    idle(1);
    expect_reg("flag cleared", `WD_CAUSE_ADDR, 8'h00);
    unlock(0, 8'h00);
    expect_reg("enable cleared", `WD_CTRL_ADDR, 8'h00);
    $display("test reset_mode done");
  endtask : t_reset_mode

  task automatic t_irq_mode();
    int n;
    unlock(0, 8'h01);
    wr8(`WD_CTRL_ADDR, 8'h41);
    idle(1);
    pulse_restart();
    wait_evt(16400, n);
    check("irq raised", 1'b1, timeout_irq);
    check("no reset", 1'b0, sys_reset_pulse);
    check("doubled timing", 1'b1, n >= 16380 && n <= 16400);
    expect_reg("flag set", `WD_CTRL_ADDR, 8'hc1);
    wr8(`WD_CTRL_ADDR, 8'hc1);
    idle(1);
    @(negedge ref_clk);
    check("irq cleared by write", 1'b0, timeout_irq);
    expect_reg("enable kept", `WD_CTRL_ADDR, 8'h41);
    unlock(0, 8'h40);
    $display("test irq_mode done");
  endtask : t_irq_mode

  task automatic t_combined();
    int n;
    wr8(`WD_CTRL_ADDR, 8'h48);
    idle(1);
    pulse_restart();
    wait_evt(8200, n);
    check("first expiry irq", 1'b1, timeout_irq);
    check("first expiry no reset", 1'b0, sys_reset_pulse);
    @(posedge ref_clk);
    irq_vector_ack <= 1'b1;
    @(posedge ref_clk);
    irq_vector_ack <= 1'b0;
    @(negedge ref_clk);
    check("vector clears irq", 1'b0, timeout_irq);
    expect_reg("reset mode left", `WD_CTRL_ADDR, 8'h08);
    wait_evt(8200, n);
    check("second expiry reset", 1'b1, sys_reset_pulse);
    check("second expiry timing", 1'b1, n >= 8100);
    idle(2 * HOLD);
    wr8(`WD_CAUSE_ADDR, 8'h00);
    unlock(0, 8'h00);
    $display("test combined done");
  endtask : t_combined

  task automatic t_select();
    unlock(2, 8'h21);
    expect_reg("longest select", `WD_CTRL_ADDR, 8'h21);
    unlock(1, 8'h22);
    expect_reg("reserved ignored", `WD_CTRL_ADDR, 8'h21);
    unlock(0, 8'h00);
    expect_reg("select back", `WD_CTRL_ADDR, 8'h00);
    $display("test select done");
  endtask : t_select

  task automatic t_stop();
    int n;
    pulse_restart();
    wait_evt(8400, n);
    check("stopped no action", 8400, n);
    $display("test stop done");
  endtask : t_stop

  // Runs last, since a write taken under the fuse may leave stored bits that only show once it is released.
  task automatic t_fuse();
    @(posedge ref_clk);
    always_on_fuse <= 1'b1;
    idle(4);
    expect_reg("fuse forces reset", `WD_CTRL_ADDR, 8'h08);
    wr8(`WD_CTRL_ADDR, 8'h40);
    unlock(0, 8'h40);
    expect_reg("fuse locks bits", `WD_CTRL_ADDR, 8'h08);
    $display("test fuse done");
  endtask : t_fuse

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic end_of_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // The whole sequence needs about 60000 cycles; the limit leaves ample margin.
  initial begin
    #(LIMIT_NS);
    failures++;
    $display("watchdog limit reached");
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_unlock();
    t_reset_mode();
    t_irq_mode();
    t_combined();
    t_select();
    t_stop();
    t_fuse();
    end_of_test();
  end
endmodule : test_watchdog_timer_with_reset
